// ### rtl/ext_bus_defines.vh
// constants for the memory map decoder and external bus sequencer
`ifndef EXT_BUS_DEFINES_VH
`define EXT_BUS_DEFINES_VH

// internal sram size and window bounds
`define SRAM_DEPTH          1024
`define SRAM_AW             10
`define DATA_RAM_TOP        16'h03FF
`define CODE_RAM_BASE       16'h0400
`define CODE_RAM_TOP        16'h07FF

// power management register fields
`define PMR_DATA_RAM_EN     0
`define PMR_MAP_SEL_HIGH    1
`define PMR_ALE_ALWAYS      2
// on-chip code size register field
`define CSZ_PROG_RAM_EN     3
// access control register fields
`define ACCESS_CONTROL_REG_PAGE_EN        7
`define ACCESS_CONTROL_REG_PAGE_SEL_HI    6
`define ACCESS_CONTROL_REG_PAGE_SEL_LO    5

// reset values
`define PMR_RESET           8'h00
`define ACCESS_CONTROL_REG_RESET          8'h00
`define CSZ_RESET           8'h00

// timed access unlock sequence
`define TA_KEY1             8'hAA
`define TA_KEY2             8'h55
`define TA_WINDOW_CYCLES    2'h3

// page select encodings
`define PSEL_1CYC           2'h0
`define PSEL_2CYC           2'h1
`define PSEL_4CYC           2'h2
`define PSEL_MODE2          2'h3

// memory cycle lengths in system clocks
`define NONPAGE_EXT_CLKS    4'h4
`define PAGE_DATA_CLKS      4'h4
`define PM2_HIT_CLKS        4'h2
`define PM2_MISS_CLKS       4'h4

`endif

// ### rtl/sram_1k.v
// internal 1kB single-port sram with registered read data
`timescale 1ns/1ps
`include "ext_bus_defines.vh"

module sram_1k #(
  parameter DEPTH = `SRAM_DEPTH,
  parameter AW    = `SRAM_AW
) (
  // clock
  input  wire          i_clk_sys,
  // access port
  input  wire          i_en,
  input  wire          i_we,
  input  wire [AW-1:0] i_addr,
  input  wire [7:0]    i_wdata,
  output reg  [7:0]    o_rdata
);

  // no reset on the array: contents survive any map change
  reg [7:0] mem [0:DEPTH-1];

  always @(posedge i_clk_sys) begin
    if (i_en) begin
      if (i_we) begin
        mem[i_addr] <= i_wdata;
      end
      o_rdata <= mem[i_addr];
    end
  end

endmodule // sram_1k

// ### rtl/memory_map_and_external_bus.v
// memory map decoder and external bus sequencer
//
// Overview of operation
// (R1) internal sram disabled after power-on reset
// (R2) enabled data ram serves data below 0400h
// (R3) data above internal range goes external
// (R4) data ram enable cleared on every reset
// (R5) sram contents kept across enable changes
// (R6) map select 00 external, x1 low internal
// (R7) program ram maps code 0400h-07FFh internally
// (R8) external-only strap low blocks program ram
// (R9) both enables make shared program/data sram
// (R10) nonpage: low port address/data, high address
// (R11) program store strobe gates external memory
// (R12) nonpage: external fetch 4, internal 1
// (R13) latch strobe on external, optional internal
// (R14) program store strobe only on external fetch
// (R15) page enable selects page bus structure
// (R16) page select 00/01/10 sets mode 1 timing
// (R17) page select 11 is page mode 2
// (R18) page modes: data access always four clocks
// (R19) page mode 1: low data, high address
// (R20) page mode 2: low address, high data
// (R21) every reset restores nonpage bus
// (R22) access control writes need timed unlock
// (R23) software writes AAh then 55h first
`timescale 1ns/1ps
`include "ext_bus_defines.vh"

module memory_map_and_external_bus (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_reset,
  // special register writes from the core
  input  wire        i_timed_access_wr,
  input  wire        i_power_mgmt_wr,
  input  wire        i_code_size_wr,
  input  wire        i_access_ctrl_wr,
  input  wire [7:0]  i_reg_wdata,
  // strap
  input  wire        i_external_only_strap,
  // access request from the core
  input  wire        i_req,
  input  wire        i_req_code,
  input  wire        i_req_write,
  input  wire [15:0] i_req_addr,
  input  wire [7:0]  i_req_wdata,
  output reg         o_req_ready,
  output reg         o_done,
  output reg         o_done_internal,
  output reg  [7:0]  o_rdata,
  // external bus pins
  input  wire [7:0]  i_low_port,
  output reg  [7:0]  o_low_port,
  output reg         o_low_port_oe,
  input  wire [7:0]  i_high_port,
  output reg  [7:0]  o_high_port,
  output reg         o_high_port_oe,
  output reg         o_latch_strobe,
  output reg         o_program_store_strobe_n,
  output reg         o_read_strobe_n,
  output reg         o_write_strobe_n,
  // register readback
  output reg  [7:0]  o_power_mgmt,
  output reg  [7:0]  o_code_size,
  output reg  [7:0]  o_access_ctrl,
  output reg         o_timed_access_open
);

  localparam ST_IDLE = 2'h0;
  localparam ST_INT  = 2'h1;
  localparam ST_EXT  = 2'h2;

  reg  [1:0]  state_q;
  reg  [3:0]  cnt_q;
  reg  [3:0]  len_q;
  reg  [3:0]  ale_len_q;
  reg  [1:0]  bus_mode_q;   // 0 nonpage, 1 page mode 1, 2 page mode 2
  reg  [15:0] addr_q;
  reg  [7:0]  wdata_q;
  reg         code_q;
  reg         write_q;
  reg  [7:0]  last_page_q;
  reg         page_valid_q;
  reg         force_miss_q;
  reg  [1:0]  ta_stage_q;
  reg  [1:0]  ta_cnt_q;
  reg         strap_q;
  reg         strap_taken_q;

  wire [7:0]  sram_rdata;
  wire        data_ram_en  = o_power_mgmt[`PMR_DATA_RAM_EN];
  wire        ale_always   = o_power_mgmt[`PMR_ALE_ALWAYS];
  wire        page_en      = o_access_ctrl[`ACCESS_CONTROL_REG_PAGE_EN];
  wire [1:0]  page_sel     = {o_access_ctrl[`ACCESS_CONTROL_REG_PAGE_SEL_HI],
                              o_access_ctrl[`ACCESS_CONTROL_REG_PAGE_SEL_LO]};
  wire        prog_ram_en  = o_code_size[`CSZ_PROG_RAM_EN]
                             & strap_q; // see (R8)
  wire        ta_open      = (ta_stage_q == 2'h2);

  // internal hit decode, shared by data and code
  function is_internal;
    input        code;
    input [15:0] a;
    input        den;
    input        pen;
    begin
      if (code) begin
        is_internal = pen && a >= `CODE_RAM_BASE
                      && a <= `CODE_RAM_TOP;          // see (R7)
      end else begin
        is_internal = den && a <= `DATA_RAM_TOP;      // see (R2) (R3) (R6)
      end
    end
  endfunction

  // length of an external cycle for page mode 1 selections
  function [3:0] pm1_len;
    input [1:0] sel;
    input       miss;
    begin
      if (sel == `PSEL_1CYC) begin
        pm1_len = miss ? 4'h2 : 4'h1;
      end else if (sel == `PSEL_2CYC) begin
        pm1_len = miss ? 4'h4 : 4'h2;
      end else begin
        pm1_len = miss ? 4'h8 : 4'h4;
      end
    end
  endfunction

  wire        req_int  = is_internal(i_req_code, i_req_addr,
                                     data_ram_en, prog_ram_en); // see (R9)
  wire        take     = i_req && (state_q == ST_IDLE);
  wire        new_miss = !page_valid_q || force_miss_q
                         || (last_page_q != i_req_addr[15:8])
                         || (!i_req_code && page_sel == `PSEL_1CYC);

  reg  [3:0]  len_d;
  reg  [3:0]  ale_len_d;
  reg  [1:0]  mode_d;

  // cycle length and address phase of a new external access
  always @* begin
    len_d     = `NONPAGE_EXT_CLKS;
    ale_len_d = 4'h1;
    mode_d    = 2'h0;
    if (!page_en) begin
      len_d     = `NONPAGE_EXT_CLKS;                    // see (R12) (R15)
      ale_len_d = 4'h1;
    end else if (page_sel == `PSEL_MODE2) begin
      mode_d    = 2'h2;                                  // see (R17)
      if (!i_req_code) begin
        len_d = `PAGE_DATA_CLKS;                         // see (R18)
      end else begin
        len_d = new_miss ? `PM2_MISS_CLKS : `PM2_HIT_CLKS;
      end
      ale_len_d = new_miss ? {1'b0, len_d[3:1]} : 4'h0;
    end else begin
      mode_d    = 2'h1;
      if (!i_req_code) begin
        len_d = `PAGE_DATA_CLKS;                         // see (R18)
      end else begin
        len_d = pm1_len(page_sel, new_miss);             // see (R16)
      end
      ale_len_d = new_miss ? {1'b0, len_d[3:1]} : 4'h0;
    end
  end

  // sram port: only internal requests touch it
  sram_1k u_sram (
    .i_clk_sys (i_clk_sys),
    .i_en      (take && req_int),
    .i_we      (i_req_write && !i_req_code),
    .i_addr    (i_req_addr[`SRAM_AW-1:0]),
    .i_wdata   (i_req_wdata),
    .o_rdata   (sram_rdata)
  );

  // register file, timed access and strap capture
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_power_mgmt        <= `PMR_RESET;      // see (R1) (R4)
      o_code_size         <= `CSZ_RESET;
      o_access_ctrl       <= `ACCESS_CONTROL_REG_RESET;     // see (R21)
      ta_stage_q          <= 2'h0;
      ta_cnt_q            <= 2'h0;
      o_timed_access_open <= 1'b0;
      strap_q             <= 1'b0;
      strap_taken_q       <= 1'b0;
    end else begin
      // strap is caught once, on the first clock after release
      if (!strap_taken_q) begin
        strap_q       <= i_external_only_strap;
        strap_taken_q <= 1'b1;
      end
      if (i_power_mgmt_wr) begin
        o_power_mgmt <= i_reg_wdata;          // see (R5)
      end
      // unlock: key1 then key2, window lasts a few clocks
      if (i_timed_access_wr) begin
        if (i_reg_wdata == `TA_KEY1) begin
          ta_stage_q <= 2'h1;                 // see (R23)
        end else if (i_reg_wdata == `TA_KEY2 && ta_stage_q == 2'h1) begin
          ta_stage_q <= 2'h2;
          ta_cnt_q   <= `TA_WINDOW_CYCLES;
        end else begin
          ta_stage_q <= 2'h0;
        end
      end else if (ta_open && (i_access_ctrl_wr || i_code_size_wr)) begin
        ta_stage_q <= 2'h0;
      end else if (ta_open) begin
        if (ta_cnt_q == 2'h1) begin
          ta_stage_q <= 2'h0;
        end
        ta_cnt_q <= ta_cnt_q - 2'h1;
      end
      if (i_access_ctrl_wr && ta_open) begin
        o_access_ctrl <= i_reg_wdata;         // see (R22)
      end
      if (i_code_size_wr && ta_open) begin
        o_code_size <= i_reg_wdata;
      end
      o_timed_access_open <= (ta_stage_q == 2'h1 && i_timed_access_wr
                              && i_reg_wdata == `TA_KEY2)
                             || (ta_open && !i_access_ctrl_wr
                                 && !i_code_size_wr && ta_cnt_q != 2'h1
                                 && !i_timed_access_wr);
    end
  end

  wire       last    = (cnt_q == len_q - 4'h1);
  wire [3:0] cnt_nx  = cnt_q + 4'h1;
  wire       addr_ph = (cnt_nx < ale_len_q);

  // access sequencer and pin drivers
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      state_q                  <= ST_IDLE;
      cnt_q                    <= 4'h0;
      len_q                    <= 4'h1;
      ale_len_q                <= 4'h0;
      bus_mode_q               <= 2'h0;
      addr_q                   <= 16'h0000;
      wdata_q                  <= 8'h00;
      code_q                   <= 1'b0;
      write_q                  <= 1'b0;
      last_page_q              <= 8'h00;
      page_valid_q             <= 1'b0;
      force_miss_q             <= 1'b0;
      o_req_ready              <= 1'b0;
      o_done                   <= 1'b0;
      o_done_internal          <= 1'b0;
      o_rdata                  <= 8'h00;
      o_low_port               <= 8'h00;
      o_low_port_oe            <= 1'b0;
      o_high_port              <= 8'h00;
      o_high_port_oe           <= 1'b0;
      o_latch_strobe           <= 1'b0;
      o_program_store_strobe_n <= 1'b1;
      o_read_strobe_n          <= 1'b1;
      o_write_strobe_n         <= 1'b1;
    end else begin
      o_done          <= 1'b0;
      o_done_internal <= 1'b0;
      o_latch_strobe  <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          o_req_ready <= 1'b1;
          if (take) begin
            o_req_ready <= 1'b0;
            addr_q      <= i_req_addr;
            wdata_q     <= i_req_wdata;
            code_q      <= i_req_code;
            write_q     <= i_req_write && !i_req_code;
            cnt_q       <= 4'h0;
            if (req_int) begin
              state_q        <= ST_INT;           // see (R12)
              o_latch_strobe <= i_req_code && ale_always; // see (R13)
            end else begin
              state_q      <= ST_EXT;
              len_q        <= len_d;
              ale_len_q    <= ale_len_d;
              bus_mode_q   <= mode_d;
              last_page_q  <= i_req_addr[15:8];
              page_valid_q <= 1'b1;
              // one-clock page mode misses around data moves
              force_miss_q <= !i_req_code && page_sel == `PSEL_1CYC;
              o_latch_strobe <= (ale_len_d != 4'h0);  // see (R13)
              if (mode_d == 2'h0) begin
                o_low_port     <= i_req_addr[7:0];    // see (R10)
                o_low_port_oe  <= 1'b1;
                o_high_port    <= i_req_addr[15:8];
                o_high_port_oe <= 1'b1;
              end else if (mode_d == 2'h1) begin
                o_high_port    <= (ale_len_d != 4'h0) ? i_req_addr[15:8]
                                                      : i_req_addr[7:0];
                o_high_port_oe <= 1'b1;               // see (R19)
                o_low_port_oe  <= 1'b0;
              end else begin
                o_low_port     <= i_req_addr[7:0];    // see (R20)
                o_low_port_oe  <= 1'b1;
                o_high_port    <= i_req_addr[15:8];
                o_high_port_oe <= 1'b1;
              end
              if (ale_len_d == 4'h0) begin
                o_program_store_strobe_n <= !i_req_code; // see (R11) (R14)
                o_read_strobe_n  <= i_req_code || i_req_write;
                o_write_strobe_n <= i_req_code || !i_req_write;
                if (mode_d == 2'h1 && i_req_write && !i_req_code) begin
                  o_low_port    <= i_req_wdata;
                  o_low_port_oe <= 1'b1;
                end
              end
            end
          end
        end
        ST_INT: begin
          // sram data is registered, one clock per access
          o_rdata         <= sram_rdata;
          o_done          <= 1'b1;
          o_done_internal <= 1'b1;
          o_req_ready     <= 1'b1;
          state_q         <= ST_IDLE;
        end
        ST_EXT: begin
          if (last) begin
            o_rdata <= (bus_mode_q == 2'h2) ? i_high_port : i_low_port;
            o_done                   <= 1'b1;
            o_req_ready              <= 1'b1;
            state_q                  <= ST_IDLE;
            o_program_store_strobe_n <= 1'b1;
            o_read_strobe_n          <= 1'b1;
            o_write_strobe_n         <= 1'b1;
            o_low_port_oe            <= 1'b0;
            o_high_port_oe           <= (bus_mode_q != 2'h2);
          end else begin
            cnt_q          <= cnt_nx;
            o_latch_strobe <= addr_ph;
            if (!addr_ph) begin
              o_program_store_strobe_n <= !code_q;   // see (R14)
              o_read_strobe_n          <= code_q || write_q;
              o_write_strobe_n         <= !write_q;
              if (bus_mode_q == 2'h0) begin
                o_low_port    <= wdata_q;
                o_low_port_oe <= write_q;
              end else if (bus_mode_q == 2'h1) begin
                o_high_port   <= addr_q[7:0];
                o_low_port    <= wdata_q;
                o_low_port_oe <= write_q;
              end else begin
                o_high_port    <= wdata_q;
                o_high_port_oe <= write_q;
              end
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // memory_map_and_external_bus

// ### test/memory_map_and_external_bus_assertions.sv
// concurrent checks on the external bus sequencer ports
`timescale 1ns/1ps
module ext_bus_checker (
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  // request side
  input wire logic        i_req,
  input wire logic        i_req_code,
  input wire logic [15:0] i_req_addr,
  input wire logic        o_req_ready,
  input wire logic        o_done,
  input wire logic        o_done_internal,
  // pins and readback
  input wire logic        o_latch_strobe,
  input wire logic        o_program_store_strobe_n,
  input wire logic        o_low_port_oe,
  input wire logic [7:0]  o_power_mgmt,
  input wire logic [7:0]  o_code_size,
  input wire logic [7:0]  o_access_ctrl,
  input wire logic        o_timed_access_open
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire take  = i_req && o_req_ready;
  wire low1k = i_req_addr[15:10] == 6'h00;
  wire cwin  = i_req_addr[15:10] == 6'h01;
  wire pg    = o_access_ctrl[7];
  // surely external, whatever the strap says
  wire cext  = i_req_code && (!o_code_size[3] || !cwin);
  wire dext  = !i_req_code && (!o_power_mgmt[0] || !low1k);

  chk_reset_clear: assert property ($fell(i_reset) |->
    o_power_mgmt == 8'h00 && o_code_size == 8'h00 && o_access_ctrl == 8'h00)
    else $error("registers not clear after reset");
  chk_ext_fetch_len: assert property (take && cext && !pg |->
    ##1 (!o_done) [*4] ##1 (o_done && !o_done_internal))
    else $error("nonpage external fetch length wrong");
  chk_int_data_len: assert property (take && !i_req_code &&
    o_power_mgmt[0] && low1k |-> ##1 !o_done ##1 (o_done && o_done_internal))
    else $error("internal data access wrong");
  chk_data_high_ext: assert property (take && !i_req_code && !low1k
    |-> ##[2:9] (o_done && !o_done_internal))
    else $error("high data access not external");
  chk_page_data_len: assert property (take && dext && pg |->
    ##1 (!o_done) [*4] ##1 o_done)
    else $error("page mode data access not four clocks");
  chk_pm2_code_len: assert property (take && cext &&
    o_access_ctrl[7:5] == 3'b111 |-> ##[3:5] o_done)
    else $error("page mode 2 fetch length wrong");
  chk_strobe_internal: assert property (o_done && o_done_internal
    |-> $past(o_program_store_strobe_n) && $past(o_program_store_strobe_n, 2))
    else $error("store strobe during internal access");
  chk_latch_then_strobe: assert property (
    $fell(o_program_store_strobe_n) && !pg |-> $past(o_latch_strobe))
    else $error("store strobe without address latch");
  chk_addr_drive: assert property (
    o_latch_strobe && !pg && !o_power_mgmt[2] |-> o_low_port_oe)
    else $error("low port not driving address");
  chk_unlock_first: assert property (
    $changed(o_access_ctrl) || $changed(o_code_size) |->
    $past(o_timed_access_open))
    else $error("protected register changed while locked");
  cov_page_fetch: cover property (take && cext && pg);
  cov_internal: cover property (o_done && o_done_internal);
  cov_access_control_reg_write: cover property ($changed(o_access_ctrl));
endmodule // ext_bus_checker

bind memory_map_and_external_bus ext_bus_checker u_chk (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_req(i_req),
  .i_req_code(i_req_code), .i_req_addr(i_req_addr),
  .o_req_ready(o_req_ready), .o_done(o_done),
  .o_done_internal(o_done_internal), .o_latch_strobe(o_latch_strobe),
  .o_program_store_strobe_n(o_program_store_strobe_n),
  .o_low_port_oe(o_low_port_oe), .o_power_mgmt(o_power_mgmt),
  .o_code_size(o_code_size), .o_access_ctrl(o_access_ctrl),
  .o_timed_access_open(o_timed_access_open));

// ### test/ext_mem_model.sv
// external address latch and byte-wide memory on the bus pins
`timescale 1ns/1ps
module ext_mem_model (
  // clock
  input  wire logic       i_clk_sys,
  // pins from the block
  input  wire logic [7:0] i_low_drive,
  input  wire logic [7:0] i_high_drive,
  input  wire logic       i_latch_strobe,
  input  wire logic       i_pss_n,
  input  wire logic       i_rd_n,
  // pins back to the block
  output wire logic [7:0] o_low_pin,
  output wire logic [7:0] o_high_pin
);
  logic [7:0] addr_lo;
  logic [7:0] last_q = 8'h00;
  // memory outputs gated by the strobes only
  wire        mem_oe = !i_pss_n || !i_rd_n;
  wire [7:0]  rd_val = addr_lo ^ i_high_drive ^ 8'hA5;
  // latch taken on the clock so a same-step port change cannot leak in
  always @(posedge i_clk_sys) begin
    if (i_latch_strobe) begin
      addr_lo <= i_low_drive;
    end
  end
  // released low lines toggle so stale data never looks valid
  always @(posedge i_clk_sys) begin
    last_q <= o_low_pin;
  end
  assign o_low_pin  = mem_oe ? rd_val : ~last_q;
  assign o_high_pin = ~i_high_drive;
endmodule // ext_mem_model

// ### test/memory_map_and_external_bus_tb.sv
// self-checking bench for the memory map and external bus sequencer
`timescale 1ns/1ps
`include "ext_bus_defines.vh"
module memory_map_and_external_bus_tb;
  logic        i_clk_sys = 1'b0;
  logic        i_reset   = 1'b1;
  logic [3:0]  wr        = 4'h0;
  logic [7:0]  wdat      = 8'h00;
  logic        strap     = 1'b1;
  logic        req       = 1'b0;
  logic        rcode     = 1'b0;
  logic        rwr       = 1'b0;
  logic [15:0] raddr     = 16'h0000;
  logic [7:0]  rwd       = 8'h00;
  wire         ready, done, dint_w, lat, pss_n, rd_n, wr_n, lo_oe, hi_oe, ta;
  wire  [7:0]  rdata, lo_o, hi_o, m_lo, m_hi, pm, csz, access_control_reg;
  wire  [7:0]  lo_w = lo_oe ? lo_o : m_lo;
  wire  [7:0]  hi_w = hi_oe ? hi_o : m_hi;
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  logic        lat_seen, pss_seen, dint;
  logic [7:0]  got, wgot;

  memory_map_and_external_bus dut (
    .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_timed_access_wr(wr[0]),
    .i_power_mgmt_wr(wr[1]), .i_code_size_wr(wr[2]),
    .i_access_ctrl_wr(wr[3]), .i_reg_wdata(wdat),
    .i_external_only_strap(strap), .i_req(req), .i_req_code(rcode),
    .i_req_write(rwr), .i_req_addr(raddr), .i_req_wdata(rwd),
    .o_req_ready(ready), .o_done(done), .o_done_internal(dint_w),
    .o_rdata(rdata), .i_low_port(lo_w), .o_low_port(lo_o),
    .o_low_port_oe(lo_oe), .i_high_port(hi_w), .o_high_port(hi_o),
    .o_high_port_oe(hi_oe), .o_latch_strobe(lat),
    .o_program_store_strobe_n(pss_n), .o_read_strobe_n(rd_n),
    .o_write_strobe_n(wr_n), .o_power_mgmt(pm), .o_code_size(csz),
    .o_access_ctrl(access_control_reg), .o_timed_access_open(ta));
  ext_mem_model u_mem (
    .i_clk_sys(i_clk_sys), .i_low_drive(lo_o), .i_high_drive(hi_o),
    .i_latch_strobe(lat), .i_pss_n(pss_n), .i_rd_n(rd_n),
    .o_low_pin(m_lo), .o_high_pin(m_hi));

  initial begin
    forever #10 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      summarize();
    end
  end

  task summarize;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask
  task do_reset(input logic s);
    @(posedge i_clk_sys);
    i_reset <= 1'b1;
    strap   <= s;
    repeat (5) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  // idx: 0 timed access, 1 power, 2 code size, 3 access control
  task wreg(input int idx, input logic [7:0] d, input logic unlk);
    if (unlk) begin
      @(posedge i_clk_sys);
      wr   <= 4'h1;
      wdat <= `TA_KEY1;
      @(posedge i_clk_sys);
      wdat <= `TA_KEY2;
    end
    @(posedge i_clk_sys);
    wr   <= 4'h1 << idx;
    wdat <= d;
    @(posedge i_clk_sys);
    wr   <= 4'h0;
    #1;
  endtask
  // n counts edges from take to done
  task acc(input logic c, input logic w, input logic [15:0] a);
    @(posedge i_clk_sys);
    req   <= 1'b1;
    rcode <= c;
    rwr   <= w;
    raddr <= a;
    rwd   <= 8'h3C;
    #1;
    lat_seen = lat;
    pss_seen = 1'b0;
    wgot     = 8'h00;
    @(posedge i_clk_sys);
    req <= 1'b0;
    n = 1;
    #1;
    // look just after each edge, while the done pulse still stands
    while (n < 20 && done !== 1'b1) begin
      lat_seen = lat_seen | lat;
      pss_seen = pss_seen | !pss_n;
      if (!wr_n) begin
        wgot = lo_w;
      end
      @(posedge i_clk_sys);
      n++;
      #1;
    end
    got  = rdata;
    dint = dint_w;
  endtask

  task t_reset;
    check(pm === 8'h00 && csz === 8'h00, "enables not clear");
    check(access_control_reg === 8'h00 && ready === 1'b1, "bus not nonpage");
  endtask
  task t_nonpage;
    acc(1'b1, 1'b0, 16'h1234);
    check(n === `NONPAGE_EXT_CLKS + 1, "external fetch length");
    check(got === 8'h83 && dint === 1'b0, "fetch data");
    check(pss_seen && lat_seen, "strobes missing");
  endtask
  task t_data_ram;
    wreg(1, 8'h01, 1'b0);
    acc(1'b0, 1'b1, 16'h0010);
    check(dint === 1'b1 && n === 2, "internal write");
    acc(1'b0, 1'b0, 16'h0010);
    check(got === 8'h3C && !pss_seen, "internal read");
    acc(1'b0, 1'b0, 16'h0400);
    check(dint === 1'b0 && got === 8'hA1, "high data read");
    acc(1'b0, 1'b1, 16'h0400);
    check(wgot === 8'h3C && dint === 1'b0, "external write");
    wreg(1, 8'h00, 1'b0);
    acc(1'b0, 1'b0, 16'h0010);
    check(dint === 1'b0 && got === 8'hB5, "map 00 read");
    wreg(1, 8'h02, 1'b0);
    acc(1'b0, 1'b0, 16'h0010);
    check(dint === 1'b0, "reserved map read");
    wreg(1, 8'h01, 1'b0);
    acc(1'b0, 1'b0, 16'h0010);
    check(got === 8'h3C, "sram lost contents");
  endtask
  task t_prog_ram;
    wreg(2, 8'h08, 1'b0);
    check(csz === 8'h00, "locked write accepted");
    wreg(2, 8'h08, 1'b1);
    check(csz === 8'h08, "unlocked write lost");
    acc(1'b1, 1'b0, 16'h0410);
    check(dint === 1'b1 && got === 8'h3C, "shared ram");
    check(!pss_seen && !lat_seen, "internal strobe");
    wreg(1, 8'h05, 1'b0);
    acc(1'b1, 1'b0, 16'h0410);
    check(lat_seen === 1'b1, "latch always-on ignored");
    do_reset(1'b0);
    wreg(2, 8'h08, 1'b1);
    acc(1'b1, 1'b0, 16'h0410);
    check(dint === 1'b0 && n === 5, "strap low allowed ram");
    do_reset(1'b1);
  endtask
  task t_page;
    int hit;
    int miss;
    for (int i = 0; i < 4; i++) begin
      hit  = (i == 3) ? `PM2_HIT_CLKS : (1 << i);
      miss = (i == 3) ? `PM2_MISS_CLKS : (2 << i);
      wreg(3, {1'b1, 2'(i), 5'h00}, 1'b1);
      check(access_control_reg[7] === 1'b1, "page enable lost");
      acc(1'b1, 1'b0, 16'h2000);
      acc(1'b1, 1'b0, 16'h2001);
      check(n === hit + 1, "page hit length");
      acc(1'b1, 1'b0, 16'h3001);
      check(n === miss + 1, "page miss length");
      acc(1'b0, 1'b0, 16'h5000);
      check(n === `PAGE_DATA_CLKS + 1, "page data length");
    end
    wreg(3, 8'h00, 1'b1);
    acc(1'b1, 1'b0, 16'h1234);
    check(n === 5 && got === 8'h83, "nonpage not restored");
    wreg(3, 8'hE0, 1'b1);
    do_reset(1'b1);
    acc(1'b1, 1'b0, 16'h1234);
    check(n === 5 && access_control_reg === 8'h00, "reset kept page mode");
  endtask

  initial begin
    do_reset(1'b1);
    t_reset();
    t_nonpage();
    t_data_ram();
    t_prog_ram();
    t_page();
    summarize();
  end
endmodule // memory_map_and_external_bus_tb
